/* shared/pbc_pkg.sv */
package pbc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] POWER_MODE_CONTROL_ADDR = 8'h08;
  localparam logic [7:0] PLL_ON_CONTROL_ADDR = 8'h09;
  localparam logic [7:0] PLL_FACTOR_AUTOBAND_CONTROL_ADDR = 8'h0A;
  localparam logic [7:0] BANDWIDTH_SELECT_CONTROL_ADDR = 8'h0F;

  // Field positions.
  localparam int unsigned POWER_MODE_LSB = 0;
  localparam int unsigned PLL_ON_BIT = 2;
  localparam int unsigned PLL_FACTOR_LSB = 0;
  localparam int unsigned PLL_FACTOR_W = 6;
  localparam int unsigned AUTOBAND_EN_BIT = 6;
  localparam int unsigned PLL_LOCK_BIT = 7;
  localparam int unsigned BW_LSB = 5;

  // Reset values.
  localparam logic [1:0] POWER_MODE_RST = 2'h0;
  localparam logic PLL_ON_RST = 1'b0;
  localparam logic [5:0] PLL_FACTOR_RST = 6'h08;
  localparam logic [1:0] BW_RST = 2'h0;

  // ----------------------------------------------------------------
  // Strap decoding
  // ----------------------------------------------------------------
  localparam logic [4:0] STRAP_DIRECT_CODE = 5'h1F;
  localparam logic [4:0] STRAP_LAST_TABLE_CODE = 5'h10;
  localparam logic [5:0] STRAP_HIGH_FACTOR = 6'h2A;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PBC_PM_NORMAL = 2'b00,
    PBC_PM_POWERDOWN = 2'b01,
    PBC_PM_STANDBY = 2'b10,
    PBC_PM_SLEEP = 2'b11
  } pbc_pmode_t;

  typedef enum logic [1:0] {
    PBC_AB_IDLE = 2'b00,
    PBC_AB_STEP = 2'b01,
    PBC_AB_DONE = 2'b10
  } pbc_ab_state_t;

  // Bandwidth codes and stage counts.
  localparam logic [1:0] BW_10MHZ = 2'h0;
  localparam logic [1:0] BW_5MHZ = 2'h1;
  localparam logic [1:0] STAGES_NONE = 2'h0;
  localparam logic [1:0] STAGES_ONE = 2'h1;
  localparam logic [1:0] STAGES_TWO = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WAKE_PD_NS = 1000;
  localparam int unsigned WAKE_STANDBY_NS = 10000;
  localparam int unsigned WAKE_SLEEP_NS = 40000;
  localparam int unsigned LOCK_TIME_NS = 20000;
  localparam int unsigned BAND_SETTLE_NS = 500;
  localparam int unsigned WAKE_PD_CYC = (WAKE_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_STANDBY_CYC = (WAKE_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_SLEEP_CYC = (WAKE_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BAND_SETTLE_CYC = (BAND_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 13;

endpackage : pbc_pkg

/* design/pbc_rate_div.sv */
module pbc_rate_div
  import pbc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [1:0] stages,
  output logic rate_en
);

  // ----------------------------------------------------------------
  // Cascaded halving
  // ----------------------------------------------------------------
  logic [1:0] cnt_q, cnt_d;
  logic rate_en_q, rate_en_d;
  logic [1:0] mask;

  // Each inserted stage halves the rate, so the pulse comes every 2^stages cycles; stages 3 gives every 4 cycles, as 2 does.
  always_comb begin
    mask = (stages == STAGES_NONE) ? 2'h0 : ((stages == STAGES_ONE) ? 2'h1 : 2'h3);
    cnt_d = run ? cnt_q + 2'h1 : 2'h0;
    rate_en_d = run && ((cnt_q & mask) == mask);
  end

  // Registered so that the enable leaves the block glitch free.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 2'h0;
      rate_en_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rate_en_q <= rate_en_d;
    end
  end

  assign rate_en = rate_en_q;

endmodule : pbc_rate_div

/* design/pbc_config.sv */
// Summary of operation
// - Serial port stays inactive from reset until its first access, then registers rule.
// - While serial port inactive, PLL factor comes from the five strap pins.
// - Strap codes 0..16 map to the factor table; 17..30 give 42.
// - Strap code 31 disables the PLL and clocks the modulator directly.
// - Setting autoband enable bit 6 while the PLL is enabled starts automatic VCO band selection.
// - Autoband picks one optimal band among all bands reaching the target.
// - Power field selects normal, power-down, standby or sleep.
// - Standby stops clocks and channels, keeps references and CMOS drivers.
// - Sleep powers everything down and disables CMOS drivers.
// - Wake-up delay grows with circuitry switched off; sleep slowest.
// - Without serial port, power-down pin high selects power-down mode.
// - Bandwidth 10 MHz uses no halving stage, 5 MHz one, 2.5 MHz two.
// - Bandwidth comes from bits 6 to 5 of bandwidth register.
// - Each halving stage halves the rate into the fixed filter.
// - After PLL enable, lock is reported in bit 7 of PLL register.
module pbc_config
  import pbc_pkg::*;
#(
  parameter int unsigned NUM_BANDS = 16,
  parameter int unsigned BAND_W = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_access,
  input wire logic reg_write,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [4:0] pll_factor_strap_pins,
  input wire logic powerdown_pin,
  input wire logic vco_in_range,
  output logic serial_active,
  output logic pll_enable,
  output logic pll_bypass,
  output logic [5:0] pll_factor,
  output logic pll_locked,
  output logic [BAND_W-1:0] vco_band,
  output logic autoband_busy,
  output logic [1:0] power_mode,
  output logic analog_on,
  output logic clocks_on,
  output logic ref_on,
  output logic channel_out_en,
  output logic cmos_drv_en,
  output logic wake_ready,
  output logic [1:0] decim_stages,
  output logic filter_rate_en
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] strap_to_factor(input logic [4:0] code);
    case (code)
      5'h00: return 6'h08;
      5'h01: return 6'h09;
      5'h02: return 6'h0A;
      5'h03: return 6'h0C;
      5'h04: return 6'h0E;
      5'h05: return 6'h0F;
      5'h06: return 6'h10;
      5'h07: return 6'h11;
      5'h08: return 6'h12;
      5'h09: return 6'h14;
      5'h0A: return 6'h15;
      5'h0B: return 6'h18;
      5'h0C: return 6'h19;
      5'h0D: return 6'h1C;
      5'h0E: return 6'h1E;
      5'h0F: return 6'h20;
      5'h10: return 6'h22;
      default: return STRAP_HIGH_FACTOR;
    endcase
  endfunction : strap_to_factor

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic serial_active_q, serial_active_d;
  logic [1:0] pmode_reg_q, pmode_reg_d;
  logic pll_on_bit_q, pll_on_bit_d;
  logic [5:0] pll_factor_field_q, pll_factor_field_d;
  logic ab_en_q, ab_en_d;
  logic [1:0] bw_q, bw_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic lock_q;
  // The first access of any kind wakes the serial port for good.
  always_comb begin
    serial_active_d = serial_active_q | reg_access;
    pmode_reg_d = pmode_reg_q;
    pll_on_bit_d = pll_on_bit_q;
    pll_factor_field_d = pll_factor_field_q;
    ab_en_d = ab_en_q;
    bw_d = bw_q;
    rdata_d = rdata_q;
    if (reg_access && reg_write) begin
      case (reg_addr)
        POWER_MODE_CONTROL_ADDR: pmode_reg_d = reg_wdata[POWER_MODE_LSB +: 2];
        PLL_ON_CONTROL_ADDR: pll_on_bit_d = reg_wdata[PLL_ON_BIT];
        PLL_FACTOR_AUTOBAND_CONTROL_ADDR: begin
          pll_factor_field_d = reg_wdata[PLL_FACTOR_LSB +: PLL_FACTOR_W];
          ab_en_d = reg_wdata[AUTOBAND_EN_BIT];
        end
        BANDWIDTH_SELECT_CONTROL_ADDR: bw_d = reg_wdata[BW_LSB +: 2];
        default: ;
      endcase
    end else if (reg_access) begin
      case (reg_addr)
        POWER_MODE_CONTROL_ADDR: rdata_d = {6'h00, pmode_reg_q};
        PLL_ON_CONTROL_ADDR: rdata_d = {5'h00, pll_on_bit_q, 2'h0};
        PLL_FACTOR_AUTOBAND_CONTROL_ADDR: rdata_d = {lock_q, ab_en_q, pll_factor_field_q};
        BANDWIDTH_SELECT_CONTROL_ADDR: rdata_d = {1'b0, bw_q, 5'h00};
        default: rdata_d = 8'h00;
      endcase
    end
  end
  // Register state; reset loads constants only.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_active_q <= 1'b0;
      pmode_reg_q <= POWER_MODE_RST;
      pll_on_bit_q <= PLL_ON_RST;
      pll_factor_field_q <= PLL_FACTOR_RST;
      ab_en_q <= 1'b0;
      bw_q <= BW_RST;
      rdata_q <= 8'h00;
    end else begin
      serial_active_q <= serial_active_d;
      pmode_reg_q <= pmode_reg_d;
      pll_on_bit_q <= pll_on_bit_d;
      pll_factor_field_q <= pll_factor_field_d;
      ab_en_q <= ab_en_d;
      bw_q <= bw_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign serial_active = serial_active_q;
  // ----------------------------------------------------------------
  // Clock source and power mode selection
  // ----------------------------------------------------------------
  logic [1:0] pmode_q, pmode_d;
  logic [5:0] factor_q, factor_d;
  logic pll_en_q, pll_en_d;
  logic bypass_q, bypass_d;
  logic [CNT_W-1:0] wake_cnt_q, wake_cnt_d;
  logic [CNT_W-1:0] lock_cnt_q, lock_cnt_d;
  logic lock_d;
  // Straps rule until the host talks; afterwards only the registers matter.
  always_comb begin
    if (serial_active_q) begin
      factor_d = pll_factor_field_q;
      pll_en_d = pll_on_bit_q;
      bypass_d = !pll_on_bit_q;
      pmode_d = pmode_reg_q;
    end else begin
      factor_d = strap_to_factor(pll_factor_strap_pins);
      bypass_d = (pll_factor_strap_pins == STRAP_DIRECT_CODE);
      pll_en_d = !bypass_d;
      pmode_d = powerdown_pin ? PBC_PM_POWERDOWN : PBC_PM_NORMAL;
    end
    // A deeper mode leaves more to restart, so the wake wait is longer.
    wake_cnt_d = (wake_cnt_q != '0) ? wake_cnt_q - 1'b1 : wake_cnt_q;
    if (pmode_d == PBC_PM_NORMAL && pmode_q != PBC_PM_NORMAL) begin
      case (pmode_q)
        PBC_PM_POWERDOWN: wake_cnt_d = CNT_W'(WAKE_PD_CYC);
        PBC_PM_STANDBY: wake_cnt_d = CNT_W'(WAKE_STANDBY_CYC);
        default: wake_cnt_d = CNT_W'(WAKE_SLEEP_CYC);
      endcase
    end
    // Lock is lost whenever the PLL or its clocks are switched off.
    lock_cnt_d = lock_cnt_q;
    lock_d = lock_q;
    if (!pll_en_q || pmode_q == PBC_PM_STANDBY || pmode_q == PBC_PM_SLEEP) begin
      lock_cnt_d = CNT_W'(LOCK_CYC);
      lock_d = 1'b0;
    end else if (lock_cnt_q != '0) begin
      lock_cnt_d = lock_cnt_q - 1'b1;
    end else begin
      lock_d = 1'b1;
    end
  end
  // Applied clocking and power state, bypassed from reset until straps are seen.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pmode_q <= PBC_PM_NORMAL;
      factor_q <= PLL_FACTOR_RST;
      pll_en_q <= 1'b0;
      bypass_q <= 1'b1;
      wake_cnt_q <= '0;
      lock_cnt_q <= CNT_W'(LOCK_CYC);
      lock_q <= 1'b0;
    end else begin
      pmode_q <= pmode_d;
      factor_q <= factor_d;
      pll_en_q <= pll_en_d;
      bypass_q <= bypass_d;
      wake_cnt_q <= wake_cnt_d;
      lock_cnt_q <= lock_cnt_d;
      lock_q <= lock_d;
    end
  end
  // Power domain controls decoded from the applied mode.
  assign power_mode = pmode_q;
  assign analog_on = (pmode_q == PBC_PM_NORMAL);
  assign clocks_on = (pmode_q == PBC_PM_NORMAL) || (pmode_q == PBC_PM_POWERDOWN);
  assign channel_out_en = clocks_on;
  assign ref_on = (pmode_q != PBC_PM_SLEEP);
  assign cmos_drv_en = (pmode_q != PBC_PM_SLEEP);
  assign wake_ready = (pmode_q == PBC_PM_NORMAL) && (wake_cnt_q == '0);
  assign pll_factor = factor_q;
  assign pll_enable = pll_en_q;
  assign pll_bypass = bypass_q;
  assign pll_locked = lock_q;
  // ----------------------------------------------------------------
  // Automatic VCO band selection
  // ----------------------------------------------------------------
  pbc_ab_state_t ab_state_q, ab_state_d;
  logic ab_en_prev_q;
  logic [BAND_W-1:0] band_q, band_d, first_q, first_d, last_q, last_d;
  logic found_q, found_d;
  logic [CNT_W-1:0] settle_q, settle_d;
  // Every band is tried; the centre of the passing run has the most margin.
  always_comb begin
    ab_state_d = ab_state_q;
    band_d = band_q;
    first_d = first_q;
    last_d = last_q;
    found_d = found_q;
    settle_d = settle_q;
    case (ab_state_q)
      PBC_AB_IDLE, PBC_AB_DONE: begin
        if (ab_en_q && !ab_en_prev_q && pll_en_q) begin
          ab_state_d = PBC_AB_STEP;
          band_d = '0;
          found_d = 1'b0;
          settle_d = CNT_W'(BAND_SETTLE_CYC);
        end
      end
      PBC_AB_STEP: begin
        if (!pll_en_q) begin
          ab_state_d = PBC_AB_IDLE;
        end else if (settle_q != '0) begin
          settle_d = settle_q - 1'b1;
        end else begin
          if (vco_in_range) begin
            first_d = found_q ? first_q : band_q;
            last_d = band_q;
            found_d = 1'b1;
          end
          settle_d = CNT_W'(BAND_SETTLE_CYC);
          if (band_q == BAND_W'(NUM_BANDS - 1)) begin
            ab_state_d = PBC_AB_DONE;
            if (found_d) begin
              band_d = BAND_W'(({1'b0, first_d} + {1'b0, last_d}) >> 1);
            end
          end else begin
            band_d = band_q + 1'b1;
          end
        end
      end
      default: ab_state_d = PBC_AB_IDLE;
    endcase
  end
  // Search state; the previous enable value feeds the start edge detector.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ab_state_q <= PBC_AB_IDLE;
      ab_en_prev_q <= 1'b0;
      band_q <= '0;
      first_q <= '0;
      last_q <= '0;
      found_q <= 1'b0;
      settle_q <= '0;
    end else begin
      ab_state_q <= ab_state_d;
      ab_en_prev_q <= ab_en_q;
      band_q <= band_d;
      first_q <= first_d;
      last_q <= last_d;
      found_q <= found_d;
      settle_q <= settle_d;
    end
  end
  assign vco_band = band_q;
  assign autoband_busy = (ab_state_q == PBC_AB_STEP);
  // ----------------------------------------------------------------
  // Bandwidth selection
  // ----------------------------------------------------------------
  // Unused code 3 falls to the narrowest band rather than to an illegal stage count.
  always_comb begin
    case (bw_q)
      BW_10MHZ: decim_stages = STAGES_NONE;
      BW_5MHZ: decim_stages = STAGES_ONE;
      default: decim_stages = STAGES_TWO;
    endcase
  end

  pbc_rate_div u_rate_div (.clk(clk), .arst_n(arst_n), .run(clocks_on), .stages(decim_stages),
    .rate_en(filter_rate_en));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_serial_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    serial_active_q |=> serial_active_q) else $error("serial port fell back to straps");
  chk_strap_factor: assert property (@(posedge clk) disable iff (!arst_n)
    (!serial_active_q && pll_factor_strap_pins == 5'h10 && $stable(pll_factor_strap_pins))
    |=> (pll_factor == 6'h22 || serial_active_q)) else $error("strap 16 not factor 34");
  chk_strap_direct: assert property (@(posedge clk) disable iff (!arst_n)
    (!serial_active_q && !reg_access && pll_factor_strap_pins == STRAP_DIRECT_CODE)
    |=> pll_bypass && !pll_enable) else $error("strap 31 not direct clocking");
  chk_pdpin_mode: assert property (@(posedge clk) disable iff (!arst_n)
    (!serial_active_q && !reg_access && powerdown_pin) |=> power_mode == PBC_PM_POWERDOWN)
    else $error("power-down pin ignored");
  chk_standby_domains: assert property (@(posedge clk) disable iff (!arst_n)
    power_mode == PBC_PM_STANDBY |-> !clocks_on && !channel_out_en && ref_on && cmos_drv_en)
    else $error("standby domains wrong");
  chk_sleep_domains: assert property (@(posedge clk) disable iff (!arst_n)
    power_mode == PBC_PM_SLEEP |-> !ref_on && !cmos_drv_en && !analog_on) else $error("sleep domains wrong");
  chk_wake_order: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(power_mode) == PBC_PM_SLEEP && power_mode == PBC_PM_NORMAL)
    |-> !wake_ready [*8]) else $error("sleep wake too short");
  chk_lock_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (!pll_enable && !$past(pll_enable)) |-> !pll_locked) else $error("lock without PLL");
  chk_autoband_start: assert property (@(posedge clk) disable iff (!arst_n)
    ($rose(ab_en_q) && pll_en_q && !autoband_busy) |=> autoband_busy) else $error("autoband did not start");
  chk_bw_rate: assert property (@(posedge clk) disable iff (!arst_n)
    (filter_rate_en && decim_stages == STAGES_ONE && $stable(decim_stages) && clocks_on)
    |=> !filter_rate_en) else $error("half rate enable too dense");
endmodule : pbc_config

/* bench/pbc_vco_model.sv */
// ----------------------------------------------------------------
// Analog VCO stand-in
// ----------------------------------------------------------------
module pbc_vco_model (
  input wire logic [3:0] vco_band,
  input wire logic [3:0] band_lo,
  input wire logic [3:0] band_hi,
  output logic vco_in_range
);
  timeunit 1ns;
  timeprecision 1ps;

  // Several overlapping bands reach the target, so the model reports a whole window.
  // The device has to settle on one of them, which is why a single band would test too little.
  assign vco_in_range = (vco_band >= band_lo) && (vco_band <= band_hi);
endmodule : pbc_vco_model

/* bench/tb.sv */
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: value %0h, expected %0h", $time, (got), (exp)); end end

module tb
  import pbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int CYC_LIMIT = 20000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_access = 1'b0;
  logic reg_write = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [4:0] pll_factor_strap_pins = 5'h00;
  logic powerdown_pin = 1'b0;
  logic [3:0] band_lo = 4'h0;
  logic [3:0] band_hi = 4'h0;
  logic [7:0] lfsr_q = 8'h4C;
  logic [7:0] reg_rdata;
  logic vco_in_range, serial_active, pll_enable, pll_bypass, pll_locked, autoband_busy;
  logic [5:0] pll_factor;
  logic [3:0] vco_band;
  logic [1:0] power_mode, decim_stages;
  logic analog_on, clocks_on, ref_on, channel_out_en, cmos_drv_en, wake_ready, filter_rate_en;
  int err_total = 0;
  int check_count = 0;
  int cyc_count = 0;

  // Free-running clock at 100 MHz.
  always #5 clk = ~clk;

  pbc_config pbc_config_i (.clk(clk), .arst_n(arst_n), .reg_access(reg_access), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pll_factor_strap_pins(pll_factor_strap_pins), .powerdown_pin(powerdown_pin),
    .vco_in_range(vco_in_range), .serial_active(serial_active), .pll_enable(pll_enable),
    .pll_bypass(pll_bypass), .pll_factor(pll_factor), .pll_locked(pll_locked), .vco_band(vco_band),
    .autoband_busy(autoband_busy), .power_mode(power_mode), .analog_on(analog_on),
    .clocks_on(clocks_on), .ref_on(ref_on), .channel_out_en(channel_out_en),
    .cmos_drv_en(cmos_drv_en), .wake_ready(wake_ready), .decim_stages(decim_stages),
    .filter_rate_en(filter_rate_en));

  pbc_vco_model pbc_vco_model_i (.vco_band(vco_band), .band_lo(band_lo), .band_hi(band_hi),
    .vco_in_range(vco_in_range));

  // ----------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  function automatic logic [5:0] strap_factor(input logic [4:0] c);
    logic [5:0] tbl [0:16];
    tbl = '{6'h08, 6'h09, 6'h0A, 6'h0C, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h14, 6'h15, 6'h18,
      6'h19, 6'h1C, 6'h1E, 6'h20, 6'h22};
    if (c <= 5'h10) begin
      return tbl[c];
    end
    return 6'h2A;
  endfunction : strap_factor

  // Packed as analog, clocks, reference, channel outputs, CMOS drivers; channels follow the clocks.
  function automatic logic [4:0] mode_outs(input logic [1:0] m);
    return {m == 2'h0, m < 2'h2, m != 2'h3, m < 2'h2, m != 2'h3};
  endfunction : mode_outs

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_access <= 1'b1;
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_access <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_access <= 1'b1;
    reg_write <= 1'b0;
    reg_addr <= a;
    @(posedge clk);
    reg_access <= 1'b0;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask : reg_rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Toggling the enable bit is what re-arms the search, so every run clears it first.
  task automatic run_band();
    logic [3:0] lo;
    logic [3:0] hi;
    int n;
    lfsr_q = lfsr_next(lfsr_q);
    lo = {1'b0, lfsr_q[2:0]};
    hi = lo + {2'b00, lfsr_q[5:4]};
    @(posedge clk);
    band_lo <= lo;
    band_hi <= hi;
    reg_wr(PLL_FACTOR_AUTOBAND_CONTROL_ADDR, 8'h2A);
    reg_wr(PLL_FACTOR_AUTOBAND_CONTROL_ADDR, 8'h6A);
    settle(3);
    `CHK(autoband_busy, 1'b1)
    n = 0;
    while (autoband_busy !== 1'b0 && n < 1000) begin
      settle(1);
      n++;
    end
    `CHK(vco_band, lo + ((hi - lo) >> 1))
  endtask : run_band

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // A hang counts as a mismatch and still reaches the report.
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == CYC_LIMIT) begin
      err_total++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] rd;
    int n;
    int wk [0:3];
    wk = '{0, WAKE_PD_CYC, WAKE_STANDBY_CYC, WAKE_SLEEP_CYC};
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    settle(2);
    `CHK(serial_active, 1'b0)
    for (int c = 0; c < 32; c++) begin
      @(posedge clk);
      pll_factor_strap_pins <= c[4:0];
      settle(3);
      `CHK(pll_bypass, c == 31)
      `CHK(pll_enable, c != 31)
      if (c != 31) `CHK(pll_factor, strap_factor(c[4:0]))
    end
    @(posedge clk);
    powerdown_pin <= 1'b1;
    settle(3);
    `CHK(power_mode, 2'h1)
    @(posedge clk);
    powerdown_pin <= 1'b0;
    reg_rd(8'h3C, rd);
    `CHK(rd, 8'h00)
    `CHK(serial_active, 1'b1)
    @(posedge clk);
    powerdown_pin <= 1'b1;
    settle(3);
    `CHK(pll_factor, PLL_FACTOR_RST)
    `CHK(power_mode, 2'h0)
    for (int m = 0; m < 4; m++) begin
      lfsr_q = lfsr_next(lfsr_q);
      reg_wr(POWER_MODE_CONTROL_ADDR, {lfsr_q[7:2], m[1:0]});
      settle(2);
      `CHK(power_mode, m[1:0])
      `CHK({analog_on, clocks_on, ref_on, channel_out_en, cmos_drv_en}, mode_outs(m[1:0]))
      reg_rd(POWER_MODE_CONTROL_ADDR, rd);
      `CHK(rd, {6'h00, m[1:0]})
    end
    // Wake time is counted from the write that returns to normal, so latency adds a few cycles.
    for (int m = 1; m < 4; m++) begin
      reg_wr(POWER_MODE_CONTROL_ADDR, m[7:0]);
      settle(5);
      reg_wr(POWER_MODE_CONTROL_ADDR, 8'h00);
      n = 0;
      do begin
        settle(1);
        n++;
      end while (wake_ready !== 1'b1 && n < 5000);
      `CHK(n >= wk[m] && n <= wk[m] + 3, 1'b1)
    end
    for (int b = 0; b < 4; b++) begin
      lfsr_q = lfsr_next(lfsr_q);
      reg_wr(BANDWIDTH_SELECT_CONTROL_ADDR, {lfsr_q[7], b[1:0], lfsr_q[4:0]});
      settle(3);
      `CHK(decim_stages, (b > 2) ? 2'h2 : b[1:0])
      n = 0;
      repeat (64) begin
        settle(1);
        if (filter_rate_en === 1'b1) n++;
      end
      `CHK(n, 64 >> ((b > 2) ? 2 : b))
      reg_rd(BANDWIDTH_SELECT_CONTROL_ADDR, rd);
      `CHK(rd, {1'b0, b[1:0], 5'h00})
    end
    reg_wr(PLL_FACTOR_AUTOBAND_CONTROL_ADDR, 8'h2A);
    reg_wr(PLL_ON_CONTROL_ADDR, 8'h04);
    n = 0;
    do begin
      settle(1);
      n++;
    end while (pll_locked !== 1'b1 && n < 2100);
    `CHK(n >= LOCK_CYC && n <= LOCK_CYC + 4, 1'b1)
    `CHK(pll_bypass, 1'b0)
    reg_rd(PLL_FACTOR_AUTOBAND_CONTROL_ADDR, rd);
    `CHK(rd, 8'hAA)
    run_band();
    reg_wr(POWER_MODE_CONTROL_ADDR, 8'h02);
    settle(3);
    `CHK(pll_locked, 1'b0)
    reg_wr(POWER_MODE_CONTROL_ADDR, 8'h00);
    run_band();
    give_verdict();
  end
endmodule : tb
